// ===== bench/pmc_monitor.sv
// port assertions for the clock and power-mode controller
`timescale 1ns/10ps
module pmc_monitor (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              wr,
    input wire logic              nmi_n,
    input wire logic [4:0]        wake_req,
    input wire logic              ext_bus_mode,
    input wire logic [19:0]       bus_addr_out,
    input wire logic [6:0]        bus_strobe_out,
    input wire logic              main_osc_run,
    input wire logic              pll_run,
    input wire logic              main_osc_drive_high,
    input wire pmc_pkg::pmc_src_t cpu_src,
    input wire logic [4:0]        cpu_div,
    input wire logic              stop_mode,
    input wire logic              osc_stop_irq,
    input wire logic              osc_stop_reset
);
    import pmc_pkg::*;
    logic [2:0] nmi_hi_r;
    // cycles the nmi pin has stayed high, saturating at 7
    always_ff @(posedge clk) begin
        if (reset || !nmi_n) begin
            nmi_hi_r <= 3'h0;
        end else if (nmi_hi_r != 3'h7) begin
            nmi_hi_r <= nmi_hi_r + 3'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_stop_div_drive: assert property (
        $rose(stop_mode) |-> cpu_div == 5'h08 && main_osc_drive_high)
        else $error("stop entry lacks div8 or drive high");
    a_stop_osc_off: assert property (
        stop_mode && $past(stop_mode) |-> !main_osc_run && !pll_run)
        else $error("oscillator running in stop");
    a_stop_pins_hold: assert property (
        stop_mode && $past(stop_mode) |-> $stable(bus_addr_out))
        else $error("address pins moved in stop");
    a_stop_strobes_high: assert property (
        stop_mode && $past(stop_mode) && $past(ext_bus_mode)
        |-> bus_strobe_out == 7'h7F)
        else $error("bus strobes not high in stop");
    a_wake_on_request: assert property (
        stop_mode && wake_req != 5'h00 |-> ##[1:2] !stop_mode)
        else $error("wake request did not end stop");
    a_wake_on_nmi: assert property (
        stop_mode && $fell(nmi_n) |-> ##[1:8] !stop_mode)
        else $error("nmi fall did not end stop");
    a_no_stray_wake: assert property (
        stop_mode && wake_req == 5'h00 && nmi_hi_r == 3'h7 && !wr
        |=> stop_mode)
        else $error("stop left without a wake source");
    a_wake_cpu_clock: assert property (
        $fell(stop_mode) && $past(cpu_src) != PMC_SRC_SUB
        |-> cpu_div == 5'h08)
        else $error("wake clock not divided by 8");
    a_irq_one_pulse: assert property (
        osc_stop_irq |=> !osc_stop_irq)
        else $error("detector interrupt longer than one cycle");
    a_reset_sticky: assert property (
        osc_stop_reset |=> osc_stop_reset)
        else $error("detector reset request dropped");
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the clock and power-mode controller
`timescale 1ns/10ps
module tb_top;
    import pmc_pkg::*;
    logic        clk, reset, wr, rd, nmi_n, main_osc_input, sub_osc_alive;
    logic        subclock_raw, main_osc_freq_ok, ext_bus_mode, ube_in;
    logic        clock_output_pin, main_osc_run, pll_run, drive_hi;
    logic        periph_on_ring, stop_mode, osc_stop_irq, osc_stop_reset;
    logic [7:0]  addr, wdata, rdata, io_in, io_out;
    logic [4:0]  wake_req, cpu_div;
    logic [19:0] a_in, a_out;
    logic [15:0] d_in;
    logic [3:0]  cs_in;
    logic [6:0]  st_in, st_out;
    pmc_src_t    cpu_src;
    pmc_mode_t   mode;
    int          num_errors, comparisons;
    pmc_ctrl pmc_ctrl_i (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .nmi_n(nmi_n), .wake_req(wake_req),
        .main_osc_input(main_osc_input), .sub_osc_alive(sub_osc_alive),
        .subclock_raw(subclock_raw), .main_osc_freq_ok(main_osc_freq_ok),
        .ext_bus_mode(ext_bus_mode), .bus_addr_in(a_in), .bus_data_in(d_in),
        .chip_selects_in(cs_in), .upper_byte_enable_in(ube_in),
        .bus_strobe_in(st_in), .io_port_in(io_in), .bus_addr_out(a_out),
        .bus_data_out(), .chip_selects(), .upper_byte_enable(),
        .bus_strobe_out(st_out), .io_port_out(io_out),
        .clock_output_pin(clock_output_pin), .main_osc_run(main_osc_run),
        .sub_osc_run(), .ring_osc_run(), .pll_run(pll_run),
        .main_osc_drive_high(drive_hi), .pll_mult(), .cpu_src(cpu_src),
        .cpu_div(cpu_div), .cpu_tick(), .periph_on_ring(periph_on_ring),
        .periph_clk_stop_in_wait(), .mode(mode), .stop_mode(stop_mode),
        .osc_stop_irq(osc_stop_irq), .osc_stop_reset(osc_stop_reset));
    // clock, and bus inputs that keep moving so frozen pins show
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        a_in <= a_in + 20'h00001;
        d_in <= d_in + 16'h0003;
        io_in <= io_in + 8'h05;
        cs_in <= cs_in + 4'h1;
        st_in <= st_in + 7'h09;
        ube_in <= a_in[0];
        subclock_raw <= a_in[2];
    end
    task automatic chk(input string nm, input logic [19:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic guard(input bit ok, input string nm);
        if (!ok) begin
            chk(nm, 20'h00001, 20'h00000);
            tally_and_finish;
        end
    endtask
    task automatic do_reset;
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, e);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("register", e, rdata);
    endtask
    // reset values, unmapped place, divider codes, main-off side effect
    task automatic t_regs;
        logic [7:0] rv [8] = '{8'h40, 8'h20, 0, 0, 0, 0, 8'h09, 0};
        logic [4:0] dv [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
        for (int i = 0; i < 8; i++) rd_chk(8'(i), rv[i]);
        chk("div", 5'h08, cpu_div);
        wr_reg(8'h05, 8'h03);
        wr_reg(8'h00, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h01, {c[1:0], 6'h20});
            #1 chk("div", dv[c], cpu_div);
            chk("mode", c == 0 ? PMC_HIGH : PMC_MEDIUM, mode);
        end
        wr_reg(8'h01, 8'h20);
        wr_reg(8'h00, 8'h20);
        rd_chk(8'h00, 8'h60);
        chk("div", 5'h08, cpu_div);
        wr_reg(8'h00, 8'h90);
        rd_chk(8'h00, 8'h10);
        sub_osc_alive <= 1'b1;
        repeat (2) @(posedge clk);
        wr_reg(8'h00, 8'h90);
        rd_chk(8'h00, 8'h90);
        chk("src", PMC_SRC_SUB, cpu_src);
        wr_reg(8'h00, 8'h00);
    endtask
    // pll entry from high only, refused from medium; lock freezes bits
    task automatic t_pll_lock;
        wr_reg(8'h03, 8'h82);
        wr_reg(8'h01, 8'h22);
        #1 chk("mode", PMC_PLL, mode);
        chk("src", PMC_SRC_PLL, cpu_src);
        wr_reg(8'h01, 8'h20);
        wr_reg(8'h00, 8'h40);
        wr_reg(8'h01, 8'h22);
        rd_chk(8'h01, 8'h20);
        wr_reg(8'h00, 8'h00);
        wr_reg(8'h03, 8'h00);
        wr_reg(8'h04, 8'h02);
        wr_reg(8'h05, 8'h01);
        wr_reg(8'h00, 8'hA5);
        rd_chk(8'h00, 8'h01);
        wr_reg(8'h01, 8'h21);
        rd_chk(8'h01, 8'h20);
        wr_reg(8'h03, 8'h80);
        rd_chk(8'h03, 8'h00);
        wr_reg(8'h05, 8'h03);
        wr_reg(8'h04, 8'h00);
    endtask
    // detector in interrupt mode, suppression, slow clock, reset mode
    task automatic t_detect;
        int n;
        wr_reg(8'h02, 8'h81);
        main_osc_input <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(8'h02, 8'h81);
        main_osc_input <= 1'b1;
        repeat (8) @(posedge clk);
        main_osc_freq_ok <= 1'b1;
        main_osc_input <= 1'b0;
        for (n = 0; n < 10 && osc_stop_irq !== 1'b1; n++) @(posedge clk);
        guard(n < 10, "detector irq");
        rd_chk(8'h02, 8'h8F);
        chk("ring", 1'b1, periph_on_ring);
        main_osc_input <= 1'b1;
        for (n = 0; n < 10 && osc_stop_irq !== 1'b1; n++) @(posedge clk);
        chk("suppressed", 1'b0, osc_stop_irq);
        wr_reg(8'h00, 8'h41);
        wr_reg(8'h02, 8'h01);
        main_osc_input <= 1'b0;
        for (n = 0; n < 10 && osc_stop_reset !== 1'b1; n++) @(posedge clk);
        guard(n < 10, "detector reset");
        main_osc_input <= 1'b1;
        do_reset;
    endtask
    // stop entry, pin states, and every wake source in turn
    task automatic t_stop;
        logic [19:0] a;
        logic        p;
        logic [7:0]  q;
        int          n;
        wr_reg(8'h05, 8'h01);
        for (int k = 0; k < 6; k++) begin
            wr_reg(8'h00, 8'h41 + 8'(k % 3));
            wr_reg(8'h01, 8'h01);
            repeat (2) @(posedge clk);
            #1 {a, p, q} = {a_out, clock_output_pin, io_out};
            repeat (3) @(posedge clk);
            #1 chk("addr", a, a_out);
            chk("strobes", 7'h7F, st_out);
            chk("clkpin", k % 3 ? p : 1'b1, clock_output_pin);
            chk("ports", q, io_out);
            chk("drive", 1'b1, drive_hi);
            chk("run", 1'b0, main_osc_run);
            @(posedge clk);
            if (k < 5) wake_req <= 5'h01 << k;
            else nmi_n <= 1'b0;
            for (n = 0; n < 10 && stop_mode !== 1'b0; n++) @(posedge clk);
            guard(n < 10, "wake");
            {wake_req, nmi_n} <= {5'h00, 1'b1};
            #1 chk("div", 5'h08, cpu_div);
            chk("src", PMC_SRC_MAIN, cpu_src);
            repeat (6) @(posedge clk);
        end
    endtask
    initial begin
        {wr, rd, addr, wdata, wake_req, sub_osc_alive} = '0;
        {a_in, d_in, io_in, cs_in, st_in, ube_in, subclock_raw} = '0;
        {nmi_n, main_osc_input, ext_bus_mode} = 3'h7;
        {main_osc_freq_ok, num_errors, comparisons} = '0;
        do_reset;
        t_regs;
        t_pll_lock;
        t_detect;
        t_stop;
        tally_and_finish;
    end
endmodule
bind pmc_ctrl pmc_monitor pmc_monitor_i (
    .clk(clk), .reset(reset), .wr(wr), .nmi_n(nmi_n),
    .wake_req(wake_req), .ext_bus_mode(ext_bus_mode),
    .bus_addr_out(bus_addr_out), .bus_strobe_out(bus_strobe_out),
    .main_osc_run(main_osc_run), .pll_run(pll_run),
    .main_osc_drive_high(main_osc_drive_high), .cpu_src(cpu_src),
    .cpu_div(cpu_div), .stop_mode(stop_mode),
    .osc_stop_irq(osc_stop_irq), .osc_stop_reset(osc_stop_reset));

// ===== hw/pmc_ctrl.sv
// clock and power-mode controller: modes, stop, lock, oscillator watch
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_ctrl (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [7:0]           addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [7:0]           rdata,
    input  wire logic                 nmi_n,
    input  wire logic [4:0]           wake_req,
    input  wire logic                 main_osc_input,
    input  wire logic                 sub_osc_alive,
    input  wire logic                 subclock_raw,
    input  wire logic                 main_osc_freq_ok,
    input  wire logic                 ext_bus_mode,
    input  wire logic [19:0]          bus_addr_in,
    input  wire logic [15:0]          bus_data_in,
    input  wire logic [3:0]           chip_selects_in,
    input  wire logic                 upper_byte_enable_in,
    input  wire logic [6:0]           bus_strobe_in,
    input  wire logic [7:0]           io_port_in,
    output logic [19:0]               bus_addr_out,
    output logic [15:0]               bus_data_out,
    output logic [3:0]                chip_selects,
    output logic                      upper_byte_enable,
    output logic [6:0]                bus_strobe_out,
    output logic [7:0]                io_port_out,
    output logic                      clock_output_pin,
    output logic                      main_osc_run,
    output logic                      sub_osc_run,
    output logic                      ring_osc_run,
    output logic                      pll_run,
    output logic                      main_osc_drive_high,
    output logic [2:0]                pll_mult,
    output pmc_pkg::pmc_src_t         cpu_src,
    output logic [4:0]                cpu_div,
    output logic                      cpu_tick,
    output logic                      periph_on_ring,
    output logic                      periph_clk_stop_in_wait,
    output pmc_pkg::pmc_mode_t        mode,
    output logic                      stop_mode,
    output logic                      osc_stop_irq,
    output logic                      osc_stop_reset
);
    import pmc_pkg::*;

    logic [7:0] sys0_r, sys1_r, odc_r, pll_r, pm2_r, prot_r;
    logic [7:0] sys0_nxt, sys1_nxt, odc_nxt, pll_nxt;
    logic [7:0] rdata_r;
    logic       nmi_m_r, nmi_s_r, nmi_d_r;
    logic       main_m_r, main_s_r, main_d_r;
    logic       sub_m_r, sub_s_r;
    logic       fc_m_r, fc_s_r;
    logic [3:0] tick_cnt_r;
    logic [4:0] pclk_cnt_r;
    logic       tick_r, irq_r, rst_req_r;
    logic       mrun_r, srun_r, rrun_r, prun_r, pring_r;
    pmc_mode_t  mode_r;
    pmc_src_t   src_r;
    logic [4:0] div_r;

    // bits of a new value replace the old one where the mask is set
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // cpu clock source from the selection bits
    function automatic pmc_src_t src_of(input logic [7:0] s0,
                                        input logic [7:0] s1,
                                        input logic [7:0] od,
                                        input logic [7:0] pl);
        if (s0[`PMC_B_SUB_SEL])
            src_of = PMC_SRC_SUB;
        else if (od[`PMC_B_RING_SEL])
            src_of = PMC_SRC_RING;
        else if (pl[`PMC_B_PLL_RUN] & s1[`PMC_B_PLL_SEL])
            src_of = PMC_SRC_PLL;
        else
            src_of = PMC_SRC_MAIN;
    endfunction

    // cpu clock division ratio
    function automatic logic [4:0] div_of(input logic [7:0] s0,
                                          input logic [7:0] s1);
        if (s0[`PMC_B_DIV8])
            div_of = 5'h08;
        else begin
            unique case ({s1[`PMC_B_DIV_HI], s1[`PMC_B_DIV_LO]})
                2'b00: div_of = 5'h01;
                2'b01: div_of = 5'h02;
                2'b10: div_of = 5'h04;
                2'b11: div_of = 5'h10;
            endcase
        end
    endfunction

    // operating mode named by the clock bits
    function automatic pmc_mode_t mode_of(input logic [7:0] s0,
                                          input logic [7:0] s1,
                                          input logic [7:0] od,
                                          input logic [7:0] pl);
        pmc_src_t s;
        s = src_of(s0, s1, od, pl);
        if (s1[`PMC_B_STOP])
            mode_of = PMC_STOP;
        else if (s == PMC_SRC_SUB)
            mode_of = s0[`PMC_B_MAIN_OFF] ? PMC_LOWPWR : PMC_LOW;
        else if (s == PMC_SRC_RING)
            mode_of = s0[`PMC_B_MAIN_OFF] ? PMC_RINGLP : PMC_RING;
        else if (s == PMC_SRC_PLL)
            mode_of = PMC_PLL;
        else if (div_of(s0, s1) == 5'h01)
            mode_of = PMC_HIGH;
        else
            mode_of = PMC_MEDIUM;
    endfunction

    // pll mode is reached from high speed only and leaves toward it only
    function automatic logic move_ok(input pmc_mode_t cur,
                                     input pmc_mode_t nxt);
        move_ok = 1'b1;
        if (cur == PMC_PLL && nxt != PMC_PLL && nxt != PMC_HIGH)
            move_ok = 1'b0;
        if (nxt == PMC_PLL && cur != PMC_PLL && cur != PMC_HIGH)
            move_ok = 1'b0;
    endfunction

    // register bus decode; clock registers need their protect bit
    wire hit_sys0 = addr == `PMC_A_SYS0;
    wire hit_sys1 = addr == `PMC_A_SYS1;
    wire hit_odc  = addr == `PMC_A_ODC;
    wire hit_pll  = addr == `PMC_A_PLL;
    wire hit_pm2  = addr == `PMC_A_PM2;
    wire hit_prot = addr == `PMC_A_PROT;
    wire hit_stat = addr == `PMC_A_STAT;
    wire clk_wen  = wr & prot_r[`PMC_B_PRC_CLK];
    wire wr_sys0  = clk_wen & hit_sys0;
    wire wr_sys1  = clk_wen & hit_sys1;
    wire wr_odc   = clk_wen & hit_odc;
    wire wr_pll   = clk_wen & hit_pll;
    wire wr_pm2   = wr & hit_pm2 & prot_r[`PMC_B_PRC_MODE];
    wire wr_prot  = wr & hit_prot;

    // write masks with the clock-change lock applied
    wire       locked = pm2_r[`PMC_B_LOCK];
    wire [7:0] m_sys0 = `PMC_M_SYS0 & ~(locked ? `PMC_L_SYS0 : 8'h00);
    wire [7:0] m_sys1 = `PMC_M_SYS1 & ~(locked ? `PMC_L_SYS1 : 8'h00);
    wire [7:0] m_odc  = `PMC_M_ODC & ~(locked ? `PMC_L_ODC : 8'h00);
    wire [7:0] m_pll  = `PMC_M_PLL & ~(locked ? `PMC_L_PLL : 8'h00);

    // wake from stop: nmi falling edge or any set wake_req bit
    wire nmi_fall = nmi_d_r & ~nmi_s_r;
    wire wake     = sys1_r[`PMC_B_STOP] & (nmi_fall | (|wake_req));

    // main oscillator stop and restart detection
    wire det_on   = odc_r[`PMC_B_DET_EN] & main_osc_freq_ok
                    & ~sys1_r[`PMC_B_STOP];
    wire det_stop = det_on & main_d_r & ~main_s_r;
    wire det_rest = det_on & ~main_d_r & main_s_r;
    wire det_fire = det_stop | det_rest;
    wire act_irq  = odc_r[`PMC_B_ACT_SEL];
    wire sub_ok   = sys0_r[`PMC_B_SUB_ON] & sub_s_r;

    // next values of the clock registers
    always_comb begin
        sys0_nxt = sys0_r;
        sys1_nxt = sys1_r;
        odc_nxt  = odc_r;
        pll_nxt  = pll_r;
        if (wr_sys0)
            sys0_nxt = merge(sys0_r, wdata, m_sys0);
        if (wr_sys1)
            sys1_nxt = merge(sys1_r, wdata, m_sys1);
        if (wr_odc)
            odc_nxt = merge(odc_r, wdata, m_odc);
        if (wr_odc && !wdata[`PMC_B_DET_FLAG])
            odc_nxt[`PMC_B_DET_FLAG] = 1'b0;
        if (wr_pll)
            pll_nxt = merge(pll_r, wdata, m_pll);
        if (sys0_nxt[`PMC_B_SUB_SEL] && !sys0_r[`PMC_B_SUB_SEL] && !sub_ok)
            sys0_nxt[`PMC_B_SUB_SEL] = 1'b0;
        if (!move_ok(mode_of(sys0_r, sys1_r, odc_r, pll_r),
                     mode_of(sys0_nxt, sys1_nxt, odc_nxt, pll_nxt))) begin
            sys0_nxt = sys0_r;
            sys1_nxt = sys1_r;
            odc_nxt  = odc_r;
            pll_nxt  = pll_r;
        end
        if (wr_sys0 && wdata[`PMC_B_MAIN_OFF] && sys0_nxt[`PMC_B_MAIN_OFF])
            sys0_nxt[`PMC_B_DIV8] = 1'b1;
        if (sys1_nxt[`PMC_B_STOP] && !sys1_r[`PMC_B_STOP]) begin
            sys0_nxt[`PMC_B_DIV8] = 1'b1;
            sys1_nxt[`PMC_B_DRV_HI] = 1'b1;
        end
        if (wake)
            sys1_nxt[`PMC_B_STOP] = 1'b0;
        if (det_fire && act_irq) begin
            odc_nxt[`PMC_B_DET_FLAG] = 1'b1;
            odc_nxt[`PMC_B_MAIN_STP] = det_stop;
            if (det_stop && src_r == PMC_SRC_MAIN)
                odc_nxt[`PMC_B_RING_SEL] = 1'b1;
        end
    end

    // clock registers
    always_ff @(posedge clk) begin
        if (reset) begin
            sys0_r <= `PMC_R_SYS0;
            sys1_r <= `PMC_R_SYS1;
            odc_r  <= `PMC_R_ODC;
            pll_r  <= `PMC_R_PLL;
        end else begin
            sys0_r <= sys0_nxt;
            sys1_r <= sys1_nxt;
            odc_r  <= odc_nxt;
            pll_r  <= pll_nxt;
        end
    end

    // lock and protect registers
    always_ff @(posedge clk) begin
        if (reset) begin
            pm2_r  <= `PMC_R_PM2;
            prot_r <= `PMC_R_PROT;
        end else begin
            if (wr_pm2)
                pm2_r <= wdata & `PMC_M_PM2;
            if (wr_prot)
                prot_r <= wdata & `PMC_M_PROT;
        end
    end

    // read data valid only in the cycle after the strobe
    wire [7:0] stat_v = {3'h0, sub_s_r, main_s_r, 3'(mode_r)};
    wire [7:0] rd_mux = hit_sys0 ? sys0_r :
                        hit_sys1 ? sys1_r :
                        hit_odc  ? odc_r  :
                        hit_pll  ? pll_r  :
                        hit_pm2  ? pm2_r  :
                        hit_prot ? prot_r :
                        hit_stat ? stat_v : 8'h00;
    always_ff @(posedge clk) begin
        if (reset)
            rdata_r <= 8'h00;
        else
            rdata_r <= rd ? rd_mux : 8'h00;
    end

    // two-stage synchronisers for pin-side levels
    always_ff @(posedge clk) begin
        if (reset) begin
            {nmi_m_r, nmi_s_r, nmi_d_r}    <= 3'h7;
            {main_m_r, main_s_r, main_d_r} <= 3'h0;
            {sub_m_r, sub_s_r, fc_m_r, fc_s_r} <= 4'h0;
        end else begin
            {nmi_m_r, nmi_s_r, nmi_d_r}    <= {nmi_n, nmi_m_r, nmi_s_r};
            {main_m_r, main_s_r, main_d_r} <= {main_osc_input, main_m_r,
                                               main_s_r};
            {sub_m_r, sub_s_r} <= {sub_osc_alive, sub_m_r};
            {fc_m_r, fc_s_r}   <= {subclock_raw, fc_m_r};
        end
    end

    // detector response: held reset request or one-cycle interrupt
    always_ff @(posedge clk) begin
        if (reset) begin
            rst_req_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            if (det_fire && !act_irq)
                rst_req_r <= 1'b1;
            irq_r <= det_fire & act_irq
                     & ~odc_r[`PMC_B_DET_FLAG];
        end
    end

    // oscillator enables, all off while stopped, and clock selection
    wire stp_n = ~sys1_nxt[`PMC_B_STOP];
    always_ff @(posedge clk) begin
        if (reset) begin
            mrun_r  <= 1'b0;
            srun_r  <= 1'b0;
            rrun_r  <= 1'b0;
            prun_r  <= 1'b0;
            pring_r <= 1'b0;
            src_r   <= PMC_SRC_MAIN;
            div_r   <= 5'h08;
            mode_r  <= PMC_MEDIUM;
        end else begin
            mrun_r  <= stp_n & ~sys0_nxt[`PMC_B_MAIN_OFF];
            srun_r  <= stp_n & sys0_nxt[`PMC_B_SUB_ON];
            pring_r <= odc_nxt[`PMC_B_RING_SEL]
                       | odc_nxt[`PMC_B_MAIN_STP];
            rrun_r  <= stp_n & (odc_nxt[`PMC_B_RING_SEL]
                       | odc_nxt[`PMC_B_MAIN_STP]);
            prun_r  <= stp_n & pll_nxt[`PMC_B_PLL_RUN];
            src_r   <= src_of(sys0_nxt, sys1_nxt, odc_nxt, pll_nxt);
            div_r   <= div_of(sys0_nxt, sys1_nxt);
            mode_r  <= mode_of(sys0_nxt, sys1_nxt, odc_nxt, pll_nxt);
        end
    end

    // cpu clock enable divider and peripheral clock counter
    wire [3:0] div_m1 = 4'(div_r - 5'h01);
    always_ff @(posedge clk) begin
        if (reset) begin
            tick_cnt_r <= 4'h0;
            tick_r     <= 1'b0;
            pclk_cnt_r <= 5'h00;
        end else if (sys1_r[`PMC_B_STOP]) begin
            tick_cnt_r <= 4'h0;
            tick_r     <= 1'b0;
        end else begin
            tick_r     <= tick_cnt_r >= div_m1;
            tick_cnt_r <= (tick_cnt_r >= div_m1) ? 4'h0 : tick_cnt_r + 4'h1;
            pclk_cnt_r <= pclk_cnt_r + 5'h01;
        end
    end

    // clock output source and pin freezing in stop mode
    wire [1:0] co_sel = sys0_r[`PMC_B_CO_HI:`PMC_B_CO_LO];
    wire co_fc  = co_sel == 2'(PMC_CO_FC);
    wire co_val = co_fc ? fc_s_r :
                  co_sel == 2'(PMC_CO_F8)  ? pclk_cnt_r[2] :
                  co_sel == 2'(PMC_CO_F32) ? pclk_cnt_r[4] : 1'b0;
    wire [56:0] pin_src = {bus_addr_in, bus_data_in, chip_selects_in,
                           upper_byte_enable_in, io_port_in,
                           bus_strobe_in, co_val};
    wire [56:0] pin_hi  = {49'h0, {7{ext_bus_mode}}, co_fc};
    wire [56:0] pin_q;
    pmc_pin_hold #(.W(57)) u_pins (
        .clk      (clk),
        .reset    (reset),
        .freeze   (sys1_r[`PMC_B_STOP]),
        .force_hi (pin_hi),
        .pin_in   (pin_src),
        .pin_out  (pin_q)
    );

    // outputs
    assign bus_addr_out            = pin_q[56:37];
    assign bus_data_out            = pin_q[36:21];
    assign chip_selects            = pin_q[20:17];
    assign upper_byte_enable       = pin_q[16];
    assign io_port_out             = pin_q[15:8];
    assign bus_strobe_out          = pin_q[7:1];
    assign clock_output_pin        = pin_q[0];
    assign rdata                   = rdata_r;
    assign main_osc_run            = mrun_r;
    assign sub_osc_run             = srun_r;
    assign ring_osc_run            = rrun_r;
    assign pll_run                 = prun_r;
    assign main_osc_drive_high     = sys1_r[`PMC_B_DRV_HI];
    assign pll_mult                = pll_r[2:0];
    assign cpu_src                 = src_r;
    assign cpu_div                 = div_r;
    assign cpu_tick                = tick_r;
    assign periph_on_ring          = pring_r;
    assign periph_clk_stop_in_wait = sys0_r[`PMC_B_WAIT_PSTP];
    assign mode                    = mode_r;
    assign stop_mode               = sys1_r[`PMC_B_STOP];
    assign osc_stop_irq            = irq_r;
    assign osc_stop_reset          = rst_req_r;
endmodule

// ===== hw/pmc_pin_hold.sv
// pin group that follows its source, freezes or drives high in stop mode
`timescale 1ns/10ps
module pmc_pin_hold #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         freeze,
    input  wire logic [W-1:0] force_hi,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    // frozen bits keep their level unless forced high
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_out <= '0;
        end else if (freeze) begin
            pin_out <= pin_out | force_hi;
        end else begin
            pin_out <= pin_in;
        end
    end
endmodule

// ===== hw/pmc_pkg.sv
// types shared by the clock and power-mode controller
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_HIGH, PMC_MEDIUM, PMC_LOW, PMC_LOWPWR,
        PMC_PLL, PMC_RING, PMC_RINGLP, PMC_STOP
    } pmc_mode_t;
    typedef enum logic [1:0] {
        PMC_SRC_MAIN, PMC_SRC_SUB, PMC_SRC_RING, PMC_SRC_PLL
    } pmc_src_t;
    typedef enum logic [1:0] {
        PMC_CO_OFF, PMC_CO_FC, PMC_CO_F8, PMC_CO_F32
    } pmc_clock_output_pin_t;
endpackage

// ===== hw/pmc_regs.svh
// register offsets, field positions and reset values of the clock controller
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

`define PMC_A_SYS0      8'h00
`define PMC_A_SYS1      8'h01
`define PMC_A_ODC       8'h02
`define PMC_A_PLL       8'h03
`define PMC_A_PM2       8'h04
`define PMC_A_PROT      8'h05
`define PMC_A_STAT      8'h06

// sys_clock_ctrl_0 fields (clock output select in bits 1:0)
`define PMC_B_CO_LO     0
`define PMC_B_CO_HI     1
`define PMC_B_WAIT_PSTP 2
`define PMC_B_SUB_ON    4
`define PMC_B_MAIN_OFF  5
`define PMC_B_DIV8      6
`define PMC_B_SUB_SEL   7

// sys_clock_ctrl_1 fields
`define PMC_B_STOP      0
`define PMC_B_PLL_SEL   1
`define PMC_B_DRV_HI    5
`define PMC_B_DIV_LO    6
`define PMC_B_DIV_HI    7

// osc_detect_ctrl fields
`define PMC_B_DET_EN    0
`define PMC_B_RING_SEL  1
`define PMC_B_DET_FLAG  2
`define PMC_B_MAIN_STP  3
`define PMC_B_ACT_SEL   7

// pll_control_reg, processor_mode_reg_2, protect_reg fields
`define PMC_B_PLL_RUN   7
`define PMC_B_LOCK      1
`define PMC_B_PRC_CLK   0
`define PMC_B_PRC_MODE  1

// writable bits and bits frozen by the clock-change lock
`define PMC_M_SYS0      8'hF7
`define PMC_M_SYS1      8'hE3
`define PMC_M_ODC       8'h87
`define PMC_M_PLL       8'h87
`define PMC_M_PM2       8'h02
`define PMC_M_PROT      8'h03
`define PMC_L_SYS0      8'hA4
`define PMC_L_SYS1      8'h03
`define PMC_L_ODC       8'h01
`define PMC_L_PLL       8'hFF

// reset values
`define PMC_R_SYS0      8'h40
`define PMC_R_SYS1      8'h20
`define PMC_R_ODC       8'h00
`define PMC_R_PLL       8'h00
`define PMC_R_PM2       8'h00
`define PMC_R_PROT      8'h00

`endif
